/* src/rcf_reset_cause.sv */
// Reset cause flags register with APB access and event interrupt.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// R1: Trap conflict reset sets bit 15; stays clear otherwise.
// R2: Reset instruction sets bit 6; clear if never executed.
// R3: Bit 5 written one enables the watchdog, zero disables it.
// R4: Watchdog time-out sets bit 4; clear otherwise.
// R5: Software may write flags; writing ones never causes a reset.
// R6: Unprogrammed watchdog fuse keeps watchdog running; bit 5 ignored.
// R7: Flags persist through later resets until software clears them; the code keeps them through sys_rst only, and por_rst reloads 0x0003.
module rcf_reset_cause
    import rcf_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire rcf_events_t events,
    input wire logic watchdog_fuse_enable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic watchdog_run,
    output logic regulator_sleep_select,
    output logic flash_regulator_sleep_select,
    output logic irq
);

    logic [15:0] cause_reg;
    logic [15:0] cause_next;
    logic [15:0] irq_status_reg;
    logic [15:0] irq_status_next;
    logic [15:0] irq_mask_reg;
    logic [15:0] irq_mask_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [15:0] set_vec;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    rcf_event_map u_map (
        .events(events),
        .set_vec(set_vec)
    );

    // Single wait-free access phase; unmapped addresses answer with error.
    assign addr_ok = (paddr == RCF_CAUSE_OFFSET) ||
                     (paddr == RCF_IRQ_STATUS_OFFSET) ||
                     (paddr == RCF_IRQ_MASK_OFFSET);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && penable && !pwrite && addr_ok;

    // Next values: software write first, hardware events win over it.
    always_comb
    begin
        cause_next = cause_reg;
        irq_status_next = irq_status_reg;
        irq_mask_next = irq_mask_reg;
        prdata_next = prdata_reg;
        if (wr_en && paddr == RCF_CAUSE_OFFSET)
        begin
            // Plain store; a written one only records, it resets nothing.
            cause_next = pwdata[15:0] & RCF_CAUSE_MASK; // R5 R3
        end
        if (wr_en && paddr == RCF_IRQ_STATUS_OFFSET)
        begin
            irq_status_next = irq_status_reg & ~pwdata[15:0];
        end
        if (wr_en && paddr == RCF_IRQ_MASK_OFFSET)
        begin
            irq_mask_next = pwdata[15:0] & RCF_EVENT_MASK;
        end
        // Sticky flags accumulate; set beats a clear in the same cycle.
        cause_next = cause_next | set_vec; // R1 R2 R4 R7
        irq_status_next = irq_status_next | set_vec;
        if (rd_en)
        begin
            unique case (paddr)
                RCF_CAUSE_OFFSET: prdata_next = {16'h0000, cause_reg};
                RCF_IRQ_STATUS_OFFSET:
                    prdata_next = {16'h0000, irq_status_reg};
                default: prdata_next = {16'h0000, irq_mask_reg};
            endcase
        end
    end

    // Cause flags load only at power-on, surviving the system reset.
    always_ff @(posedge clock)
    begin
        if (por_rst)
        begin
            cause_reg <= RCF_CAUSE_POR_VALUE;
        end
        else
        begin
            cause_reg <= cause_next; // R7
        end
    end

    // Interrupt and bus registers follow the system reset.
    always_ff @(posedge clock)
    begin
        if (sys_rst || por_rst)
        begin
            irq_status_reg <= 16'h0000;
            irq_mask_reg <= 16'h0000;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            prdata_reg <= prdata_next;
        end
    end

    // Read data must be visible in the access cycle, so bypass the flop.
    assign prdata = rd_en ? prdata_next : prdata_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);
    // Unprogrammed fuse forces the watchdog on.
    assign watchdog_run = watchdog_fuse_enable ||
                          cause_reg[RCF_WDEN_BIT]; // R6 R3
    assign regulator_sleep_select = cause_reg[RCF_VREG_BIT];
    assign flash_regulator_sleep_select = cause_reg[RCF_FLASH_VREG_BIT];

    property p_trap_sets;
        @(posedge clock) disable iff (por_rst)
        events.trap_conflict |=> cause_reg[RCF_TRAP_BIT];
    endproperty
    a_trap_sets: assert property (p_trap_sets) // R1
        else $error("trap flag not set");

    property p_soft_sets;
        @(posedge clock) disable iff (por_rst)
        events.soft_reset |=> cause_reg[RCF_SOFT_BIT];
    endproperty
    a_soft_sets: assert property (p_soft_sets) // R2
        else $error("soft reset flag not set");

    property p_wden_write;
        @(posedge clock) disable iff (por_rst)
        wr_en && paddr == RCF_CAUSE_OFFSET && !watchdog_fuse_enable
        |=> watchdog_run == ($past(pwdata[5]) || watchdog_fuse_enable);
    endproperty
    a_wden_write: assert property (p_wden_write) // R3
        else $error("watchdog enable not following write");

    property p_watchdog_timeout_flag_sets;
        @(posedge clock) disable iff (por_rst)
        events.watchdog_timeout |=> cause_reg[RCF_WATCHDOG_TIMEOUT_FLAG_BIT];
    endproperty
    a_watchdog_timeout_flag_sets: assert property (p_watchdog_timeout_flag_sets) // R4
        else $error("time-out flag not set");

    property p_write_stores;
        @(posedge clock) disable iff (por_rst)
        wr_en && paddr == RCF_CAUSE_OFFSET && set_vec == 16'h0000
        |=> cause_reg == ($past(pwdata[15:0]) & RCF_CAUSE_MASK);
    endproperty
    a_write_stores: assert property (p_write_stores) // R5
        else $error("cause write not stored");

    property p_fuse_forces;
        @(posedge clock) disable iff (por_rst)
        watchdog_fuse_enable |-> watchdog_run;
    endproperty
    a_fuse_forces: assert property (p_fuse_forces) // R6
        else $error("fuse did not force watchdog");

    property p_sticky;
        @(posedge clock) disable iff (por_rst)
        cause_reg[RCF_PIN_BIT] && !(wr_en && paddr == RCF_CAUSE_OFFSET)
        |=> cause_reg[RCF_PIN_BIT];
    endproperty
    a_sticky: assert property (p_sticky) // R7
        else $error("pin flag lost without write");

    property p_irq_level;
        @(posedge clock) disable iff (sys_rst || por_rst)
        events.brown_out ##1 irq_mask_reg[RCF_BROWN_BIT] |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt not raised");

    property p_sysrst_keeps;
        @(posedge clock) disable iff (por_rst)
        sys_rst && set_vec == 16'h0000 && !wr_en
        |=> cause_reg == $past(cause_reg);
    endproperty
    a_sysrst_keeps: assert property (p_sysrst_keeps) // R7
        else $error("cause flags lost at system reset");

    property p_status_clear;
        @(posedge clock) disable iff (sys_rst || por_rst)
        wr_en && paddr == RCF_IRQ_STATUS_OFFSET && set_vec == 16'h0000
        |=> (irq_status_reg & $past(pwdata[15:0])) == 16'h0000;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status bit not cleared by write");

    property p_unmapped_keeps;
        @(posedge clock) disable iff (por_rst)
        pslverr |=> cause_reg == ($past(cause_reg) | $past(set_vec));
    endproperty
    a_unmapped_keeps: assert property (p_unmapped_keeps)
        else $error("unmapped access changed cause flags");

    c_trap: cover property (@(posedge clock) events.trap_conflict);
    c_watchdog_timeout_flag_irq: cover property (@(posedge clock)
        events.watchdog_timeout ##1 irq);
    c_clear: cover property (@(posedge clock)
        wr_en && paddr == RCF_CAUSE_OFFSET && pwdata[15:0] == 16'h0000);
    c_brown_irq: cover property (@(posedge clock)
        events.brown_out ##1 irq);
    c_keep_reset: cover property (@(posedge clock)
        sys_rst && cause_reg[RCF_TRAP_BIT]);

endmodule : rcf_reset_cause

/* pkg/rcf_pkg.sv */
// Package with register layout, reset values and bus types of the reset cause block.
package rcf_pkg;

    // Byte offsets of the word registers on the APB bus.
    localparam logic [11:0] RCF_CAUSE_OFFSET = 12'h000;
    localparam logic [11:0] RCF_IRQ_STATUS_OFFSET = 12'h004;
    localparam logic [11:0] RCF_IRQ_MASK_OFFSET = 12'h008;

    // Bit positions of the cause and control register.
    localparam int RCF_TRAP_BIT = 15;
    localparam int RCF_ILLOP_BIT = 14;
    localparam int RCF_FLASH_VREG_BIT = 11;
    localparam int RCF_CFGMIS_BIT = 9;
    localparam int RCF_VREG_BIT = 8;
    localparam int RCF_PIN_BIT = 7;
    localparam int RCF_SOFT_BIT = 6;
    localparam int RCF_WDEN_BIT = 5;
    localparam int RCF_WATCHDOG_TIMEOUT_FLAG_BIT = 4;
    localparam int RCF_SLEEP_BIT = 3;
    localparam int RCF_IDLE_BIT = 2;
    localparam int RCF_BROWN_BIT = 1;
    localparam int RCF_POWER_BIT = 0;

    // Implemented bits; bits 13, 12 and 10 read as zero.
    localparam logic [15:0] RCF_CAUSE_MASK = 16'hcbff;
    // Power-on value: power-on and brown-out flags set.
    localparam logic [15:0] RCF_CAUSE_POR_VALUE = 16'h0003;
    // Bits that hardware sets from events or power-on (all except 11, 8, 5).
    localparam logic [15:0] RCF_EVENT_MASK = 16'hc2df;

    // Event strobes grouped as they arrive from the reset logic.
    typedef struct packed {
        logic trap_conflict;
        logic illegal_op;
        logic config_mismatch;
        logic pin_reset;
        logic soft_reset;
        logic watchdog_timeout;
        logic sleep_wake;
        logic idle_wake;
        logic brown_out;
    } rcf_events_t;

    // APB request fields from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rcf_apb_req_t;

endpackage : rcf_pkg

/* src/rcf_event_map.sv */
// Maps the event strobes onto their bit positions of the cause register.
`timescale 1ns/1ps
module rcf_event_map
    import rcf_pkg::*;
(
    input wire rcf_events_t events,
    output logic [15:0] set_vec
);

    // Place each strobe at its flag position.
    always_comb
    begin
        set_vec = 16'h0000;
        set_vec[RCF_TRAP_BIT] = events.trap_conflict;
        set_vec[RCF_ILLOP_BIT] = events.illegal_op;
        set_vec[RCF_CFGMIS_BIT] = events.config_mismatch;
        set_vec[RCF_PIN_BIT] = events.pin_reset;
        set_vec[RCF_SOFT_BIT] = events.soft_reset;
        set_vec[RCF_WATCHDOG_TIMEOUT_FLAG_BIT] = events.watchdog_timeout;
        set_vec[RCF_SLEEP_BIT] = events.sleep_wake;
        set_vec[RCF_IDLE_BIT] = events.idle_wake;
        set_vec[RCF_BROWN_BIT] = events.brown_out;
    end

endmodule : rcf_event_map

/* verification/rcf_reset_cause_tb_top.sv */
// Self-checking testbench for the reset cause flags block.
`timescale 1ns/1ps
module rcf_reset_cause_tb_top
    import rcf_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic por_rst = 1'b1;
    rcf_events_t events = '0;
    logic watchdog_fuse_enable = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, watchdog_run, irq;
    logic regulator_sleep_select, flash_regulator_sleep_select;
    logic [31:0] rd_data;
    logic rd_err;
    int error_cnt = 0;
    int n_tests = 0;

    rcf_reset_cause uut (.clock(clock), .sys_rst(sys_rst), .por_rst(por_rst),
        .events(events), .watchdog_fuse_enable(watchdog_fuse_enable),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .watchdog_run(watchdog_run),
        .regulator_sleep_select(regulator_sleep_select),
        .flash_regulator_sleep_select(flash_regulator_sleep_select),
        .irq(irq));

    // The clock toggles every half period of 50 ns.
    always #50 clock = ~clock;

    // Prints the verdict and ends the run.
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    // Compares a value and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            $display("unexpected at %0t: got %h expected %h",
                     $time, pready, 1'b1);
            error_cnt++;
            close_out();
        end
        else
        begin
            rd_data = prdata;
            rd_err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // Reads a register and compares it.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        chk(rd_data, exp);
    endtask : rd

    // Pulses one cycle of event strobes, then lets the flags land.
    task automatic ev(input logic [8:0] v);
        @(posedge clock);
        events <= rcf_events_t'(v);
        @(posedge clock);
        events <= '0;
        @(posedge clock);
    endtask : ev

    // Main sequence of tests.
    initial
    begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        rd(RCF_CAUSE_OFFSET, 32'h0000_0003);
        $display("test power_on_value done");
        apb(RCF_CAUSE_OFFSET, 1'b1, 32'h0000_0000);
        apb(RCF_IRQ_MASK_OFFSET, 1'b1, 32'h0000_8000);
        ev(9'h100);
        chk({31'h0, irq}, 32'h1);
        rd(RCF_CAUSE_OFFSET, 32'h0000_8000);
        $display("test trap_conflict done");
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        rd(RCF_CAUSE_OFFSET, 32'h0000_8000);
        ev(9'h010);
        rd(RCF_CAUSE_OFFSET, 32'h0000_8040);
        ev(9'h008);
        rd(RCF_CAUSE_OFFSET, 32'h0000_8050);
        $display("test accumulate done");
        chk({31'h0, irq}, 32'h0);
        apb(RCF_IRQ_MASK_OFFSET, 1'b1, 32'h0000_0010);
        @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        apb(RCF_IRQ_STATUS_OFFSET, 1'b1, 32'h0000_0010);
        @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        rd(RCF_IRQ_STATUS_OFFSET, 32'h0000_0040);
        $display("test interrupt done");
        apb(RCF_CAUSE_OFFSET, 1'b1, 32'hffff_ffff);
        rd(RCF_CAUSE_OFFSET, 32'h0000_cbff);
        chk({29'h0, watchdog_run, regulator_sleep_select,
             flash_regulator_sleep_select}, 32'h7);
        $display("test write_all done");
        apb(RCF_CAUSE_OFFSET, 1'b1, 32'h0000_0000);
        rd(RCF_CAUSE_OFFSET, 32'h0000_0000);
        chk({31'h0, watchdog_run}, 32'h0);
        watchdog_fuse_enable <= 1'b1;
        repeat (2) @(posedge clock);
        chk({31'h0, watchdog_run}, 32'h1);
        apb(RCF_CAUSE_OFFSET, 1'b1, 32'h0000_0020);
        watchdog_fuse_enable <= 1'b0;
        repeat (2) @(posedge clock);
        chk({31'h0, watchdog_run}, 32'h1);
        $display("test watchdog done");
        apb(12'h00c, 1'b0, 32'h0000_0000);
        chk({31'h0, rd_err}, 32'h1);
        apb(12'h00c, 1'b1, 32'hffff_ffff);
        chk({31'h0, rd_err}, 32'h1);
        rd(RCF_CAUSE_OFFSET, 32'h0000_0020);
        $display("test unmapped done");
        apb(RCF_CAUSE_OFFSET, 1'b1, 32'h0000_0000);
        apb(RCF_IRQ_MASK_OFFSET, 1'b1, 32'hffff_ffff);
        rd(RCF_IRQ_MASK_OFFSET, 32'h0000_c2df);
        apb(RCF_IRQ_MASK_OFFSET, 1'b1, 32'h0000_0002);
        ev(9'h0e7);
        chk({31'h0, irq}, 32'h1);
        rd(RCF_CAUSE_OFFSET, 32'h0000_428e);
        $display("test other_causes done");
        close_out();
    end
endmodule : rcf_reset_cause_tb_top
